/* design/sel_pkg.sv */
package sel_pkg;
  // Register byte offsets on the AXI4-Lite slave.
  localparam logic [7:0] OFS_CMD  = 8'h00;
  localparam logic [7:0] OFS_DATA = 8'h04;
  localparam logic [7:0] OFS_STAT = 8'h08;
  // Command register layout.
  localparam int BIT_BUSY    = 31;
  localparam int CMD_LSB     = 28;
  localparam int BIT_TIMEOUT = 10;
  localparam int BIT_LOADED  = 9;
  // Command codes.
  localparam logic [2:0] CMD_READ   = 3'h0;
  localparam logic [2:0] CMD_LOCK   = 3'h1;
  localparam logic [2:0] CMD_UNLOCK = 3'h2;
  localparam logic [2:0] CMD_WRITE  = 3'h3;
  localparam logic [2:0] CMD_WRAL   = 3'h4;
  localparam logic [2:0] CMD_ERASE  = 3'h5;
  localparam logic [2:0] CMD_ERAL   = 3'h6;
  localparam logic [2:0] CMD_RELOAD = 3'h7;
  // Opcode bits sent on the serial link (start bit plus two).
  localparam logic [2:0] OP_READ  = 3'h6;
  localparam logic [2:0] OP_WRITE = 3'h5;
  localparam logic [2:0] OP_ERASE = 3'h7;
  localparam logic [2:0] OP_MISC  = 3'h4;
  localparam logic [7:0] SIGNATURE  = 8'ha5;
  localparam int         SRAM_BYTES = 512;
  // Timing: serial clock half period and response timeout.
  localparam int SCK_HALF      = 4;
  localparam int CLK_HZ        = 10_000_000;
  localparam int TIMEOUT_MS    = 30;
  localparam int TIMEOUT_CYC   = CLK_HZ / 1000 * TIMEOUT_MS;
  typedef enum logic [3:0] {
    ST_IDLE, ST_START, ST_SHIFT, ST_READ, ST_CSLOW, ST_WAIT, ST_DONE
  } sel_state_t;
endpackage : sel_pkg

/* design/sel_eeprom_loader.sv */
// Functional notes
// - Every chip-level reset starts an EEPROM load.
// - First byte read must equal 0xA5 for the EEPROM to count as present.
// - With signature found, copy the whole EEPROM into 512-byte SRAM.
// - USB control unit reads descriptors from the SRAM copy.
// - USB PHY held disconnected until the load sequence ends; only the reset load does so, a reload leaves it connected.
// - Reload command in the command register reruns the load.
// - A reload fails when the first byte is not 0xA5.
// - Load-success flag set only after a successful load.
// - Host can read, write and erase single locations via registers.
// - Command and data registers sit in system CSR space.
// - Busy clears when the EEPROM write cycle completes.
// - All modifying commands: set busy, complete when busy clears.
// - No response within 30 ms: abandon and set timeout flag.
// - Read data valid in data register by the time busy clears.
// - Image offsets are counted in 16-bit words.
// - A zero length field means absent; use the hardware default.
//
// Implementation choices: the address map and the AXI4-Lite register port.
module sel_eeprom_loader (
  input  wire logic                      aclk,
  input  wire logic                      aresetn,
  input  wire logic [7:0]                s_axi_awaddr,
  input  wire logic                      s_axi_awvalid,
  output logic                           s_axi_awready,
  input  wire logic [31:0]               s_axi_wdata,
  input  wire logic [3:0]                s_axi_wstrb,
  input  wire logic                      s_axi_wvalid,
  output logic                           s_axi_wready,
  output logic [1:0]                     s_axi_bresp,
  output logic                           s_axi_bvalid,
  input  wire logic                      s_axi_bready,
  input  wire logic [7:0]                s_axi_araddr,
  input  wire logic                      s_axi_arvalid,
  output logic                           s_axi_arready,
  output logic [31:0]                    s_axi_rdata,
  output logic [1:0]                     s_axi_rresp,
  output logic                           s_axi_rvalid,
  input  wire logic                      s_axi_rready,
  output logic                           ee_cs,
  output logic                           ee_sck,
  output logic                           ee_di,
  input  wire logic                      ee_do,
  output logic                           usb_phy_disconnect,
  input  wire logic [8:0]                desc_addr,
  output logic [7:0]                     desc_data
);
  import sel_pkg::*;

  sel_state_t  state;
  logic [7:0]  sram [SRAM_BYTES];
  logic        do_s1, do_s2;
  logic [2:0]  cmd_code;
  logic [8:0]  cmd_addr;
  logic        busy, timeout, loaded;
  logic [7:0]  data_reg;
  logic        loading, load_first;
  logic [8:0]  load_addr;
  logic [4:0]  bit_cnt;
  logic [4:0]  nbits;
  logic [11:0] shreg;
  logic [7:0]  rx;
  logic [2:0]  div;
  logic [18:0] tmo;
  logic        aw_hold, w_hold;
  logic [7:0]  aw_q;
  logic [31:0] w_q;

  wire tick = (div == 3'(SCK_HALF - 1));
  wire [7:0] rx_next = {rx[6:0], do_s2};
  wire rx_is_sig = (rx_next == SIGNATURE);

  // Opcode and address bits for the serial frame, 12 bits, MSB first.
  function automatic logic [11:0] frame(input logic [2:0] c,
                                        input logic [8:0] a);
    unique case (c)
      CMD_READ, CMD_RELOAD: frame = {OP_READ, a};
      CMD_WRITE:            frame = {OP_WRITE, a};
      CMD_ERASE:            frame = {OP_ERASE, a};
      CMD_UNLOCK:           frame = {OP_MISC, 9'h180};
      CMD_LOCK:             frame = {OP_MISC, 9'h000};
      CMD_WRAL:             frame = {OP_MISC, 9'h080};
      CMD_ERAL:             frame = {OP_MISC, 9'h100};
    endcase
  endfunction : frame

  // Frame of the next transfer; a load always reads at load_addr.
  wire [11:0] next_frame = frame(loading ? CMD_READ : cmd_code,
                                 loading ? load_addr : cmd_addr);
  // Data-in moves while the serial clock is low, half a bit ahead of the
  // rising edge on which the EEPROM samples it, so the two never race.
  wire next_di = bit_cnt < 5'd11  ? shreg[10] :
                 bit_cnt == 5'd11 ? data_reg[7] : data_reg[6];

  // AXI4-Lite slave; address and data are caught in either order.
  wire wr_go = aw_hold && w_hold && !s_axi_bvalid;
  wire [7:0] wa = aw_q;
  wire cmd_wr = wr_go && wa == OFS_CMD && s_axi_wstrb[3] && !busy
                && w_q[BIT_BUSY];
  wire data_wr = wr_go && wa == OFS_DATA && s_axi_wstrb[0] && !busy;
  wire wa_ok = wa == OFS_CMD || wa == OFS_DATA || wa == OFS_STAT;
  wire [7:0] ra = s_axi_araddr;
  wire ra_ok = ra == OFS_CMD || ra == OFS_DATA || ra == OFS_STAT;
  wire [31:0] cmd_view = {busy, cmd_code, 17'h0, timeout, loaded, cmd_addr};
  wire [31:0] rd_mux = ra == OFS_CMD  ? cmd_view :
                       ra == OFS_DATA ? {24'h0, data_reg} :
                       ra == OFS_STAT ? {28'h0, 3'(state), loading} :
                       32'h0;

  assign s_axi_awready = !aw_hold;
  assign s_axi_wready  = !w_hold;
  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold <= 1'b0;
      w_hold <= 1'b0;
      aw_q <= 8'h00;
      w_q <= 32'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= 2'h0;
      s_axi_rdata <= 32'h0;
    end else begin
      if (s_axi_awvalid && !aw_hold) begin
        aw_hold <= 1'b1;
        aw_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_hold) begin
        w_hold <= 1'b1;
        w_q <= s_axi_wdata;
      end
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wa_ok ? 2'h0 : 2'h2;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        aw_hold <= 1'b0;
        w_hold <= 1'b0;
      end
      if (s_axi_arvalid && !s_axi_rvalid) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_mux;
        s_axi_rresp <= ra_ok ? 2'h0 : 2'h2;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // The serial data-out pin is asynchronous to aclk.
  always_ff @(posedge aclk) begin
    do_s1 <= ee_do;
    do_s2 <= do_s1;
  end

  // Descriptor port reads the SRAM copy only.
  // The image is kept byte for byte, so word offsets and zero lengths
  // reach the control unit unchanged.
  always_ff @(posedge aclk) begin
    desc_data <= sram[desc_addr];
  end

  always_ff @(posedge aclk) begin
    if (loading && state == ST_READ && tick && ee_sck && bit_cnt == 5'd0)
      sram[load_addr] <= {rx[6:0], do_s2};
  end

  // Serial engine. Reset starts a load at address 0.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= ST_START;
      loading <= 1'b1;
      load_first <= 1'b1;
      load_addr <= 9'h000;
      usb_phy_disconnect <= 1'b1;
      busy <= 1'b0;
      timeout <= 1'b0;
      loaded <= 1'b0;
      cmd_code <= CMD_READ;
      cmd_addr <= 9'h000;
      data_reg <= 8'h00;
      ee_cs <= 1'b0;
      ee_sck <= 1'b0;
      ee_di <= 1'b0;
      bit_cnt <= 5'd0;
      nbits <= 5'd0;
      shreg <= 12'h0;
      rx <= 8'h00;
      div <= 3'd0;
      tmo <= 19'd0;
    end else begin
      div <= tick ? 3'd0 : div + 3'd1;
      if (data_wr)
        data_reg <= w_q[7:0];
      unique case (state)
        ST_IDLE: begin
          if (cmd_wr) begin
            busy <= 1'b1;
            timeout <= 1'b0;
            cmd_code <= w_q[CMD_LSB +: 3];
            cmd_addr <= w_q[8:0];
            if (w_q[CMD_LSB +: 3] == CMD_RELOAD) begin
              loading <= 1'b1;
              load_first <= 1'b1;
              load_addr <= 9'h000;
              loaded <= 1'b0;
            end
            state <= ST_START;
          end
        end
        ST_START: if (tick) begin
          ee_cs <= 1'b1;
          ee_sck <= 1'b0;
          shreg <= next_frame;
          ee_di <= next_frame[11];
          nbits <= (!loading && (cmd_code == CMD_WRITE
                    || cmd_code == CMD_WRAL)) ? 5'd20 : 5'd12;
          bit_cnt <= 5'd0;
          state <= ST_SHIFT;
        end
        ST_SHIFT: if (tick) begin
          ee_sck <= !ee_sck;
          if (ee_sck) begin
            ee_di <= next_di;
            if (bit_cnt < 5'd12)
              shreg <= {shreg[10:0], 1'b0};
            else
              data_reg <= {data_reg[6:0], data_reg[7]};
            bit_cnt <= bit_cnt + 5'd1;
            if (bit_cnt == nbits - 5'd1) begin
              ee_di <= 1'b0;
              bit_cnt <= 5'd7;
              state <= (loading || cmd_code == CMD_READ) ? ST_READ
                                                           : ST_CSLOW;
            end
          end
        end
        ST_READ: if (tick) begin
          ee_sck <= !ee_sck;
          if (ee_sck) begin
            rx <= {rx[6:0], do_s2};
            bit_cnt <= bit_cnt - 5'd1;
            if (bit_cnt == 5'd0) begin
              ee_cs <= 1'b0;
              ee_sck <= 1'b0;
              if (!loading) begin
                data_reg <= {rx[6:0], do_s2};
                busy <= 1'b0;
                state <= ST_IDLE;
              end else if (load_first && !rx_is_sig) begin
                // Absent or blank part: keep built-in defaults.
                loading <= 1'b0;
                busy <= 1'b0;
                usb_phy_disconnect <= 1'b0;
                state <= ST_IDLE;
              end else if (load_addr == 9'(SRAM_BYTES - 1)) begin
                loading <= 1'b0;
                loaded <= 1'b1;
                busy <= 1'b0;
                usb_phy_disconnect <= 1'b0;
                state <= ST_IDLE;
              end else begin
                load_first <= 1'b0;
                load_addr <= load_addr + 9'd1;
                state <= ST_START;
              end
            end
          end
        end
        ST_CSLOW: if (tick) begin
          ee_cs <= 1'b0;
          ee_di <= 1'b0;
          tmo <= 19'd0;
          state <= (cmd_code == CMD_LOCK || cmd_code == CMD_UNLOCK)
                   ? ST_DONE : ST_WAIT;
        end
        ST_WAIT: begin
          // Ready/busy is polled with chip select high after the cycle.
          ee_cs <= 1'b1;
          tmo <= tmo + 19'd1;
          if (tmo > 19'd4 && do_s2) begin
            state <= ST_DONE;
          end else if (tmo == 19'(TIMEOUT_CYC)) begin
            timeout <= 1'b1;
            state <= ST_DONE;
          end
        end
        ST_DONE: begin
          ee_cs <= 1'b0;
          busy <= 1'b0;
          state <= ST_IDLE;
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  property p_phy_held;
    @(posedge aclk) disable iff (!aresetn)
      loading && !busy |-> usb_phy_disconnect;
  endproperty
  a_phy_held: assert property (p_phy_held)
    else $error("phy released during load");

  property p_loaded_clean;
    @(posedge aclk) disable iff (!aresetn)
      $rose(loaded) |-> $past(loading) && !loading;
  endproperty
  a_loaded_clean: assert property (p_loaded_clean)
    else $error("loaded set outside load end");

  property p_busy_on_cmd;
    @(posedge aclk) disable iff (!aresetn)
      cmd_wr && state == ST_IDLE |=> busy;
  endproperty
  a_busy_on_cmd: assert property (p_busy_on_cmd)
    else $error("busy not set by command");

  property p_timeout_bound;
    @(posedge aclk) disable iff (!aresetn)
      state == ST_WAIT |-> tmo <= 19'(TIMEOUT_CYC);
  endproperty
  a_timeout_bound: assert property (p_timeout_bound)
    else $error("timeout counter overran");

  property p_reload_starts;
    @(posedge aclk) disable iff (!aresetn)
      cmd_wr && state == ST_IDLE && w_q[CMD_LSB +: 3] == CMD_RELOAD
      |=> loading && load_addr == 9'h000;
  endproperty
  a_reload_starts: assert property (p_reload_starts)
    else $error("reload did not start");

  property p_read_data;
    @(posedge aclk) disable iff (!aresetn)
      $fell(busy) && $past(state) == ST_READ && !$past(loading)
      |-> data_reg == $past(rx_next);
  endproperty
  a_read_data: assert property (p_read_data)
    else $error("read data not ready at busy clear");

  property p_sig_fail;
    @(posedge aclk) disable iff (!aresetn)
      $fell(loading) && !loaded |-> !usb_phy_disconnect;
  endproperty
  a_sig_fail: assert property (p_sig_fail)
    else $error("phy not released after failed load");

  property p_cs_idle;
    @(posedge aclk) disable iff (!aresetn)
      state == ST_IDLE && $past(state) == ST_IDLE |-> !ee_cs;
  endproperty
  a_cs_idle: assert property (p_cs_idle)
    else $error("chip select high while idle");
endmodule : sel_eeprom_loader

/* tb/sel_ee_model.sv */
module sel_ee_model
  import sel_pkg::*;
(
  input  wire logic        ee_cs,
  input  wire logic        ee_sck,
  input  wire logic        ee_di,
  input  wire logic [15:0] prog_us,
  output logic             ee_do
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0]  mem [0:SRAM_BYTES-1];
  logic [19:0] sh;
  logic [7:0]  rd;
  logic [2:0]  op;
  logic [8:0]  ad;
  int          cnt = 0;
  logic        wen = 1'b0;
  logic        pend = 1'b0;
  initial ee_do = 1'b0;
  always @(posedge ee_sck) begin
    if (ee_cs) begin
      sh = {sh[18:0], ee_di};
      cnt++;
      if (cnt == 12) begin
        op = sh[11:9];
        ad = sh[8:0];
      end
      // Sequential reads run on into the next location.
      if (cnt >= 12 && op == OP_READ && (cnt - 12) % 8 == 0)
        rd = mem[ad + 9'((cnt - 12) / 8)];
    end
  end
  // Data moves on the falling edge so it is settled when sampled.
  always @(negedge ee_sck) begin
    if (ee_cs && cnt >= 12 && op == OP_READ) begin
      ee_do = rd[7];
      rd = {rd[6:0], 1'b0};
    end
  end
  always @(negedge ee_cs) begin
    if (cnt >= 12 && op == OP_MISC && ad[8:7] == 2'b11)
      wen = 1'b1;
    if (cnt >= 12 && op == OP_MISC && ad[8:7] == 2'b00)
      wen = 1'b0;
    if (wen && cnt >= 20 && op == OP_WRITE) begin
      mem[ad] = sh[7:0];
      pend = 1'b1;
    end
    if (wen && cnt >= 12 && op == OP_ERASE) begin
      mem[ad] = 8'hff;
      pend = 1'b1;
    end
    if (wen && cnt >= 20 && op == OP_MISC && ad[8:7] == 2'b01) begin
      for (int k = 0; k < SRAM_BYTES; k++)
        mem[k] = sh[7:0];
      pend = 1'b1;
    end
    if (wen && cnt >= 12 && op == OP_MISC && ad[8:7] == 2'b10) begin
      for (int k = 0; k < SRAM_BYTES; k++)
        mem[k] = 8'hff;
      pend = 1'b1;
    end
    // A released line must not keep looking like valid data.
    ee_do = ~ee_do;
  end
  always @(posedge ee_cs) begin
    cnt = 0;
    op = 3'h0;
    if (pend) begin
      ee_do = 1'b0;
      #(prog_us * 1000);
      ee_do = 1'b1;
      pend = 1'b0;
    end else begin
      // Selected with no cycle pending shows ready.
      ee_do = 1'b1;
    end
  end
endmodule : sel_ee_model

/* tb/tb_top.sv */
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import sel_pkg::*;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rv;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
  logic        s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
  logic        s_axi_rready = 1'b0, s_axi_awready, s_axi_wready;
  logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
  logic        ee_cs, ee_sck, ee_di, ee_do, usb_phy_disconnect;
  logic [8:0]  desc_addr = 9'h000;
  logic [7:0]  desc_data;
  logic [15:0] prog_us = 16'h2;
  logic [31:0] lf = 32'h5ba9;
  logic [7:0]  shadow [0:SRAM_BYTES-1];
  int          bad_count = 0;
  int          samples_checked = 0;
  int          i;
  sel_eeprom_loader dut (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .ee_cs, .ee_sck, .ee_di, .ee_do,
    .usb_phy_disconnect, .desc_addr, .desc_data
  );
  sel_ee_model model (.ee_cs, .ee_sck, .ee_di, .prog_us, .ee_do);
  always #50 aclk = ~aclk;
  function automatic logic [31:0] lfsr_next(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : lfsr_next
  task automatic complete_run;
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : complete_run
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // Ready levels are sampled mid-cycle; they only move on rising edges.
  task automatic bus(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    int   n;
    logic ta, tw, tr;
    if (wr) begin
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
    end else begin
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
    end
    tr = 1'b0;
    for (n = 0; n < 50 && !tr; n++) begin
      @(negedge aclk);
      ta = wr ? s_axi_awvalid & s_axi_awready
              : s_axi_arvalid & s_axi_arready;
      tw = s_axi_wvalid & s_axi_wready;
      tr = wr ? s_axi_bvalid : s_axi_rvalid;
      rsp = wr ? s_axi_bresp : s_axi_rresp;
      rv = s_axi_rdata;
      @(posedge aclk);
      if (ta && wr) s_axi_awvalid <= 1'b0;
      if (ta && !wr) s_axi_arvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
      if (tr) begin
        s_axi_bready <= 1'b0;
        s_axi_rready <= 1'b0;
      end
    end
    // Let an edge pass so a following call never assigns a ready twice.
    if (tr) @(posedge aclk);
    if (!tr) begin
      bad_count++;
      complete_run();
    end
  endtask : bus
  task automatic idle;
    int n;
    for (n = 0; n < 40000; n++) begin
      bus(1'b0, OFS_STAT, 32'h0);
      if (rv[0] === 1'b0) begin
        bus(1'b0, OFS_CMD, 32'h0);
        if (rv[BIT_BUSY] === 1'b0) return;
      end
    end
    bad_count++;
    complete_run();
  endtask : idle
  task automatic cmd(input logic [2:0] c, input logic [8:0] a);
    bus(1'b1, OFS_CMD, {1'b1, c, 19'h0, a});
    idle();
  endtask : cmd
  task automatic rd_ee(input logic [8:0] a);
    cmd(CMD_READ, a);
    bus(1'b0, OFS_DATA, 32'h0);
    chk(rv[7:0], shadow[a]);
  endtask : rd_ee
  task automatic wr_ee(input logic [8:0] a, input logic [7:0] d);
    bus(1'b1, OFS_DATA, {24'h0, d});
    cmd(CMD_WRITE, a);
    shadow[a] = d;
    chk(rv[BIT_TIMEOUT], 1'b0);
    rd_ee(a);
  endtask : wr_ee
  initial begin
    for (i = 0; i < SRAM_BYTES; i++) begin
      lf = lfsr_next(lf);
      shadow[i] = lf[7:0];
      model.mem[i] = lf[7:0];
    end
    shadow[0] = 8'h00;
    model.mem[0] = 8'h00;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    @(negedge aclk);
    chk(usb_phy_disconnect, 1'b1);
    @(posedge aclk);
    idle();
    chk(rv[BIT_LOADED], 1'b0);
    chk(usb_phy_disconnect, 1'b0);
    cmd(CMD_UNLOCK, 9'h180);
    wr_ee(9'h000, SIGNATURE);
    for (i = 0; i < 6; i++) begin
      lf = lfsr_next(lf);
      prog_us <= (i == 2) ? 16'hc8 : 16'h2;
      wr_ee((i == 0) ? 9'h1ff : {lf[15:8], 1'b1}, lf[23:16]);
    end
    cmd(CMD_ERASE, 9'h002);
    shadow[2] = 8'hff;
    rd_ee(9'h002);
    bus(1'b0, 8'h0c, 32'h0);
    chk(rsp, 2'h2);
    bus(1'b1, 8'h40, 32'h0);
    chk(rsp, 2'h2);
    aresetn <= 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    @(negedge aclk);
    chk(usb_phy_disconnect, 1'b1);
    @(posedge aclk);
    idle();
    chk(rv[BIT_LOADED], 1'b1);
    chk(usb_phy_disconnect, 1'b0);
    for (i = 0; i < SRAM_BYTES; i++) begin
      desc_addr <= 9'(i);
      @(posedge aclk);
      @(negedge aclk);
      chk(desc_data, shadow[i]);
      @(posedge aclk);
    end
    cmd(CMD_LOCK, 9'h000);
    bus(1'b1, OFS_DATA, {24'h0, ~shadow[3]});
    cmd(CMD_WRITE, 9'h003);
    rd_ee(9'h003);
    cmd(CMD_UNLOCK, 9'h180);
    lf = lfsr_next(lf);
    bus(1'b1, OFS_DATA, {24'h0, lf[7:0]});
    cmd(CMD_WRAL, 9'h000);
    for (i = 0; i < SRAM_BYTES; i++)
      shadow[i] = lf[7:0];
    rd_ee(9'h1ff);
    cmd(CMD_ERAL, 9'h000);
    for (i = 0; i < SRAM_BYTES; i++)
      shadow[i] = 8'hff;
    rd_ee({lf[15:8], 1'b0});
    wr_ee(9'h000, 8'h5a);
    cmd(CMD_RELOAD, 9'h000);
    chk(rv[BIT_LOADED], 1'b0);
    complete_run();
  end
endmodule : tb_top
